// ==== design/split_timer_cmd_irq_ctrl.sv ====
// Split-mode timer control, command aliases, interrupts and counters
//
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
// Function
// - Split bit gives two 8-bit timers, split map
// - Clear alias clears bits written one
// - Set alias sets bits written one
// - Command field always reads zero
// - Code 0 none, 1 reserved, 2 restart
// - Code 3 hard reset, ignored while enabled
// - Target 0 none, 1-2 reserved, 3 both
// - Enable register bits 6:4, 1, 0
// - Low compare match sets compare flag
// - High underflow sets flag bit 1
// - Low underflow sets flag bit 0
// - Flags stay until written one
// - Debug halt freezes unless run bit set
// - Periods are tops, reset to ones
// - Counter writes beat count and reload
module split_timer_cmd_irq_ctrl #(
	parameter int ADDR_WIDTH = 8
)(
	// APB clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB request
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	// APB answer
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	// Processor stopped in break debug
	input wire logic debug_halt,
	// Interrupt request
	output logic irq
);

	//------------------------------------------------------------
	// Parameter check
	//------------------------------------------------------------
	if (ADDR_WIDTH < 8)
	begin : g_bad_width
		$error("ADDR_WIDTH must be at least 8");
	end

	//------------------------------------------------------------
	// State
	//------------------------------------------------------------
	logic enable; // Timer running
	logic dual_byte_enable; // Split operation
	logic [1:0] command_target; // Stored target field
	logic [7:0] split_interrupt_enable; // Source enables
	logic [7:0] split_interrupt_flag; // Sticky flags
	logic run_in_debug; // Keep running in debug
	logic [7:0] low_counter, high_counter; // Byte counters
	logic [7:0] low_period, high_period; // Byte tops
	logic [7:0] low_compare [split_timer_pkg::LOW_COMPARES];

	//------------------------------------------------------------
	// Bus decode
	//------------------------------------------------------------
	logic [5:0] idx; // Word index
	logic wr; // Write takes effect
	logic split_reg, mapped; // Split-only register, address decodes
	logic [1:0] cmd; // Command code of a set-alias write
	logic [1:0] next_target; // Target after this write
	logic cmd_valid; // Both targets chosen
	logic do_restart, do_hard_reset; // Command strobes
	logic tick; // Counters step this cycle
	logic low_unf, high_unf; // Underflow events
	logic [2:0] low_match; // Compare events
	logic [7:0] flag_set, flag_clr; // Flag set and clear masks

	assign idx = paddr[7:2];
	assign wr = psel & penable & pwrite & mapped;
	assign pready = 1'b1;

	// Split-only registers vanish from the map in normal mode
	always_comb
	begin
		split_reg = 1'b1;
		mapped = 1'b1;
		unique case (idx)
			split_timer_pkg::IDX_CTRL_ENABLE,
			split_timer_pkg::IDX_DUAL_BYTE: split_reg = 1'b0;
			split_timer_pkg::IDX_CMD_CLEAR,
			split_timer_pkg::IDX_CMD_SET,
			split_timer_pkg::IDX_INT_ENABLE,
			split_timer_pkg::IDX_INT_FLAG,
			split_timer_pkg::IDX_DEBUG_RUN,
			split_timer_pkg::IDX_LOW_COUNTER,
			split_timer_pkg::IDX_HIGH_COUNTER,
			split_timer_pkg::IDX_LOW_PERIOD,
			split_timer_pkg::IDX_HIGH_PERIOD,
			6'h28, 6'h2a, 6'h2c: split_reg = 1'b1;
			default: mapped = 1'b0;
		endcase
		// Alternate map only when split is on
		if (split_reg && !dual_byte_enable)
			mapped = 1'b0;
		if (paddr[1:0] != 2'h0)
			mapped = 1'b0;
	end

	// Error on unmapped access
	assign pslverr = psel & penable & ~mapped;
	chk_split_map: assert property (@(posedge pclk)
		disable iff (!presetn) psel && penable && !dual_byte_enable &&
		idx == split_timer_pkg::IDX_INT_FLAG |-> pslverr)
		else $error("split register visible in normal map");

	//------------------------------------------------------------
	// Commands
	//------------------------------------------------------------
	// Target after a set or clear alias write
	always_comb
	begin
		next_target = command_target;
		if (wr && idx == split_timer_pkg::IDX_CMD_CLEAR)
			next_target = command_target & ~pwdata[1:0];
		else if (wr && idx == split_timer_pkg::IDX_CMD_SET)
			next_target = command_target | pwdata[1:0];
	end

	assign cmd = (wr && idx == split_timer_pkg::IDX_CMD_SET) ?
		pwdata[split_timer_pkg::CMD_LSB +: 2] :
		split_timer_pkg::CMD_NONE;
	// Only the both code selects; none and reserved do nothing
	assign cmd_valid = next_target == split_timer_pkg::TARGET_BOTH;
	assign do_restart = cmd_valid &&
		cmd == split_timer_pkg::CMD_RESTART;
	// Hard reset needs both targets and a stopped timer
	assign do_hard_reset = cmd_valid && !enable &&
		cmd == split_timer_pkg::CMD_HARD_RESET;

	// Stored target field
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			command_target <= split_timer_pkg::RESET_TARGET;
		else
			command_target <= next_target;
	end
	chk_clear_alias: assert property (@(posedge pclk)
		disable iff (!presetn) wr && idx == split_timer_pkg::IDX_CMD_CLEAR
		|=> command_target == ($past(command_target) & ~$past(pwdata[1:0])))
		else $error("clear alias wrong");
	chk_set_alias: assert property (@(posedge pclk)
		disable iff (!presetn) wr && idx == split_timer_pkg::IDX_CMD_SET
		|=> command_target == ($past(command_target) | $past(pwdata[1:0])))
		else $error("set alias wrong");
	chk_reset_ignored: assert property (@(posedge pclk)
		disable iff (!presetn) enable &&
		cmd == split_timer_pkg::CMD_HARD_RESET |=> $stable(low_period))
		else $error("hard reset while enabled");
	chk_reserved_target: assert property (@(posedge pclk)
		disable iff (!presetn) cmd != split_timer_pkg::CMD_NONE && !tick &&
		next_target != split_timer_pkg::TARGET_BOTH
		|=> $stable(low_counter) && $stable(low_period))
		else $error("command on reserved target");

	//------------------------------------------------------------
	// Control registers
	//------------------------------------------------------------
	// Enable, split, interrupt enable and debug run bits
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			enable <= 1'b0;
			dual_byte_enable <= 1'b0;
			split_interrupt_enable <= split_timer_pkg::RESET_ZERO;
			run_in_debug <= 1'b0;
		end
		else if (wr)
		begin
			unique case (idx)
				split_timer_pkg::IDX_CTRL_ENABLE:
					enable <= pwdata[split_timer_pkg::BIT_ENABLE];
				split_timer_pkg::IDX_DUAL_BYTE:
					dual_byte_enable <=
						pwdata[split_timer_pkg::BIT_DUAL_BYTE];
				split_timer_pkg::IDX_INT_ENABLE:
					split_interrupt_enable <=
						pwdata[7:0] & split_timer_pkg::INT_MASK;
				split_timer_pkg::IDX_DEBUG_RUN:
					run_in_debug <=
						pwdata[split_timer_pkg::BIT_RUN_IN_DEBUG];
				default: ;
			endcase
		end
	end

	//------------------------------------------------------------
	// Byte timers
	//------------------------------------------------------------
	// Stepping only in split mode, frozen in debug unless allowed
	assign tick = enable & dual_byte_enable &
		(~debug_halt | run_in_debug);
	assign low_unf = tick && low_counter == 8'h00;
	assign high_unf = tick && high_counter == 8'h00;
	chk_debug_halt: assert property (@(posedge pclk)
		disable iff (!presetn) debug_halt && !run_in_debug && !wr
		|=> $stable(low_counter) && $stable(high_counter))
		else $error("counter moved in debug halt");

	// Low counter: write, then command, then count and reload
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			low_counter <= split_timer_pkg::RESET_ZERO;
		else if (wr && idx == split_timer_pkg::IDX_LOW_COUNTER)
			low_counter <= pwdata[7:0];
		else if (do_hard_reset)
			low_counter <= split_timer_pkg::RESET_ZERO;
		else if (do_restart || low_unf)
			low_counter <= low_period;
		else if (tick)
			low_counter <= low_counter - 8'h01;
	end
	chk_write_wins: assert property (@(posedge pclk)
		disable iff (!presetn) wr && idx == split_timer_pkg::IDX_LOW_COUNTER
		|=> low_counter == $past(pwdata[7:0]))
		else $error("counter write lost");

	// High counter, same priority
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			high_counter <= split_timer_pkg::RESET_ZERO;
		else if (wr && idx == split_timer_pkg::IDX_HIGH_COUNTER)
			high_counter <= pwdata[7:0];
		else if (do_hard_reset)
			high_counter <= split_timer_pkg::RESET_ZERO;
		else if (do_restart || high_unf)
			high_counter <= high_period;
		else if (tick)
			high_counter <= high_counter - 8'h01;
	end
	chk_restart_load: assert property (@(posedge pclk)
		disable iff (!presetn) do_restart
		|=> high_counter == $past(high_period) &&
		low_counter == $past(low_period))
		else $error("restart did not reload");

	// Period registers; hard reset returns them to all ones
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			low_period <= split_timer_pkg::RESET_PERIOD;
			high_period <= split_timer_pkg::RESET_PERIOD;
		end
		else if (do_hard_reset)
		begin
			low_period <= split_timer_pkg::RESET_PERIOD;
			high_period <= split_timer_pkg::RESET_PERIOD;
		end
		else if (wr && idx == split_timer_pkg::IDX_LOW_PERIOD)
			low_period <= pwdata[7:0];
		else if (wr && idx == split_timer_pkg::IDX_HIGH_PERIOD)
			high_period <= pwdata[7:0];
	end

	// Compare registers and their match detectors
	for (genvar n = 0; n < split_timer_pkg::LOW_COMPARES; n++)
	begin : g_cmp
		localparam logic [5:0] MY_IDX = 6'(int'(
			split_timer_pkg::IDX_LOW_COMPARE0) +
			n * int'(split_timer_pkg::IDX_COMPARE_STEP));
		// Compare value
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				low_compare[n] <= split_timer_pkg::RESET_ZERO;
			else if (do_hard_reset)
				low_compare[n] <= split_timer_pkg::RESET_ZERO;
			else if (wr && idx == MY_IDX)
				low_compare[n] <= pwdata[7:0];
		end
		// Match while running
		assign low_match[n] = tick &&
			low_counter == low_compare[n];
	end

	//------------------------------------------------------------
	// Interrupt flags
	//------------------------------------------------------------
	always_comb
	begin
		flag_set = 8'h00;
		flag_set[split_timer_pkg::BIT_LOW_COMPARE0 +: 3] =
			low_match;
		flag_set[split_timer_pkg::BIT_HIGH_UNDERFLOW] = high_unf;
		flag_set[split_timer_pkg::BIT_LOW_UNDERFLOW] = low_unf;
	end
	assign flag_clr = (wr && idx == split_timer_pkg::IDX_INT_FLAG) ?
		pwdata[7:0] & split_timer_pkg::INT_MASK : 8'h00;

	// Sticky; a new event beats a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			split_interrupt_flag <= split_timer_pkg::RESET_ZERO;
		else
			split_interrupt_flag <=
				(split_interrupt_flag & ~flag_clr) | flag_set;
	end
	chk_cmp_flag: assert property (@(posedge pclk)
		disable iff (!presetn) low_match[1] |=> split_interrupt_flag[5])
		else $error("compare flag not set");
	chk_high_unf: assert property (@(posedge pclk)
		disable iff (!presetn) high_unf |=> split_interrupt_flag[1])
		else $error("high underflow flag not set");
	chk_low_unf: assert property (@(posedge pclk)
		disable iff (!presetn) low_unf &&
		!(wr && idx == split_timer_pkg::IDX_LOW_COUNTER)
		|=> split_interrupt_flag[0] && low_counter == $past(low_period))
		else $error("low underflow handling wrong");
	chk_flag_sticky: assert property (@(posedge pclk)
		disable iff (!presetn) split_interrupt_flag[0] && !flag_clr[0]
		|=> split_interrupt_flag[0])
		else $error("flag dropped by itself");

	// Level request
	assign irq = |(split_interrupt_flag &
		split_interrupt_enable);
	chk_irq_level: assert property (@(posedge pclk)
		disable iff (!presetn)
		irq == |(split_interrupt_flag & split_interrupt_enable))
		else $error("interrupt level wrong");

	//------------------------------------------------------------
	// Read data
	//------------------------------------------------------------
	// Latched in the setup cycle, valid through the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable)
		begin
			prdata <= 32'h0000_0000;
			if (mapped)
				unique case (idx)
					split_timer_pkg::IDX_CTRL_ENABLE:
						prdata[0] <= enable;
					split_timer_pkg::IDX_DUAL_BYTE:
						prdata[0] <= dual_byte_enable;
					// Command field reads zero
					split_timer_pkg::IDX_CMD_CLEAR,
					split_timer_pkg::IDX_CMD_SET:
						prdata[1:0] <= command_target;
					split_timer_pkg::IDX_INT_ENABLE:
						prdata[7:0] <= split_interrupt_enable;
					split_timer_pkg::IDX_INT_FLAG:
						prdata[7:0] <= split_interrupt_flag;
					split_timer_pkg::IDX_DEBUG_RUN:
						prdata[0] <= run_in_debug;
					split_timer_pkg::IDX_LOW_COUNTER:
						prdata[7:0] <= low_counter;
					split_timer_pkg::IDX_HIGH_COUNTER:
						prdata[7:0] <= high_counter;
					split_timer_pkg::IDX_LOW_PERIOD:
						prdata[7:0] <= low_period;
					split_timer_pkg::IDX_HIGH_PERIOD:
						prdata[7:0] <= high_period;
					6'h28: prdata[7:0] <= low_compare[0];
					6'h2a: prdata[7:0] <= low_compare[1];
					6'h2c: prdata[7:0] <= low_compare[2];
					default: ;
				endcase
		end
	end
	chk_cmd_zero: assert property (@(posedge pclk)
		disable iff (!presetn) psel && penable && !pwrite &&
		(idx == split_timer_pkg::IDX_CMD_SET ||
		idx == split_timer_pkg::IDX_CMD_CLEAR) |-> prdata[3:2] == 2'h0)
		else $error("command field read nonzero");

endmodule

// ==== design/split_timer_pkg.sv ====
// Constants for the split-mode timer control and status block
package split_timer_pkg;
	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_CTRL_ENABLE = 6'h00;
	localparam logic [5:0] IDX_DUAL_BYTE = 6'h03;
	localparam logic [5:0] IDX_CMD_CLEAR = 6'h04;
	localparam logic [5:0] IDX_CMD_SET = 6'h05;
	localparam logic [5:0] IDX_INT_ENABLE = 6'h0a;
	localparam logic [5:0] IDX_INT_FLAG = 6'h0b;
	localparam logic [5:0] IDX_DEBUG_RUN = 6'h0e;
	localparam logic [5:0] IDX_LOW_COUNTER = 6'h20;
	localparam logic [5:0] IDX_HIGH_COUNTER = 6'h21;
	localparam logic [5:0] IDX_LOW_PERIOD = 6'h26;
	localparam logic [5:0] IDX_HIGH_PERIOD = 6'h27;
	localparam logic [5:0] IDX_LOW_COMPARE0 = 6'h28;
	localparam logic [5:0] IDX_COMPARE_STEP = 6'h02;
	// Field positions
	localparam int BIT_ENABLE = 0;
	localparam int BIT_DUAL_BYTE = 0;
	localparam int BIT_RUN_IN_DEBUG = 0;
	localparam int BIT_LOW_UNDERFLOW = 0;
	localparam int BIT_HIGH_UNDERFLOW = 1;
	localparam int BIT_LOW_COMPARE0 = 4;
	localparam int CMD_LSB = 2;
	localparam int TARGET_LSB = 0;
	// Implemented bits of the interrupt registers
	localparam logic [7:0] INT_MASK = 8'h73;
	// Reset values
	localparam logic [7:0] RESET_ZERO = 8'h00;
	localparam logic [7:0] RESET_PERIOD = 8'hff;
	localparam logic [1:0] RESET_TARGET = 2'h0;
	// Command codes
	localparam logic [1:0] CMD_NONE = 2'h0;
	localparam logic [1:0] CMD_RESTART = 2'h2;
	localparam logic [1:0] CMD_HARD_RESET = 2'h3;
	// Command target codes
	localparam logic [1:0] TARGET_NONE = 2'h0;
	localparam logic [1:0] TARGET_BOTH = 2'h3;
	// Number of low-byte compare channels
	localparam int LOW_COMPARES = 3;
endpackage

// ==== testbench/tb_top.sv ====
// Self-checking testbench for the split-mode timer control block
`timescale 1ns/100ps
module tb_top;
	// ----------------------------------------
	// Signals and bench state
	// ----------------------------------------
	logic pclk = 1'b0; // Bus clock
	logic presetn = 1'b0; // Active-low reset
	logic psel = 1'b0; // Select
	logic penable = 1'b0; // Access phase
	logic pwrite = 1'b0; // Direction
	logic [7:0] paddr = 8'h00; // Byte address
	logic [31:0] pwdata = 32'h0000_0000; // Write data
	logic pready; // Answer
	logic pslverr; // Refusal
	logic [31:0] prdata; // Read data
	logic debug_halt = 1'b0; // Break debug
	logic irq; // Interrupt
	int failures = 0; // Mismatch count
	int samples_checked = 0; // Comparison count
	logic [31:0] rd; // Last read data
	logic [31:0] keep; // Saved read data
	logic err; // Last refusal
	// Table row: access, expected answer
	typedef struct {
		logic wr;
		logic [5:0] idx;
		logic [7:0] data;
		logic [7:0] rd_exp;
		logic err_exp;
	} row_type;
	row_type rows [18] = '{
		'{1'b0, split_timer_pkg::IDX_INT_ENABLE, 8'h00, 8'h00, 1'b0},
		'{1'b0, split_timer_pkg::IDX_INT_FLAG, 8'h00, 8'h00, 1'b0},
		'{1'b0, split_timer_pkg::IDX_DEBUG_RUN, 8'h00, 8'h00, 1'b0},
		'{1'b0, split_timer_pkg::IDX_LOW_PERIOD, 8'h00, 8'hff, 1'b0},
		'{1'b0, split_timer_pkg::IDX_HIGH_PERIOD, 8'h00, 8'hff, 1'b0},
		'{1'b0, split_timer_pkg::IDX_LOW_COUNTER, 8'h00, 8'h00, 1'b0},
		'{1'b1, split_timer_pkg::IDX_INT_ENABLE, 8'hff, 8'h00, 1'b0},
		'{1'b0, split_timer_pkg::IDX_INT_ENABLE, 8'h00, 8'h73, 1'b0},
		'{1'b1, split_timer_pkg::IDX_INT_ENABLE, 8'h00, 8'h00, 1'b0},
		'{1'b1, split_timer_pkg::IDX_CMD_SET, 8'h03, 8'h00, 1'b0},
		'{1'b1, split_timer_pkg::IDX_CMD_CLEAR, 8'h01, 8'h00, 1'b0},
		'{1'b0, split_timer_pkg::IDX_CMD_SET, 8'h00, 8'h02, 1'b0},
		'{1'b1, split_timer_pkg::IDX_CMD_SET, 8'h0d, 8'h00, 1'b0},
		'{1'b0, split_timer_pkg::IDX_CMD_CLEAR, 8'h00, 8'h03, 1'b0},
		'{1'b1, split_timer_pkg::IDX_DEBUG_RUN, 8'hff, 8'h00, 1'b0},
		'{1'b0, split_timer_pkg::IDX_DEBUG_RUN, 8'h00, 8'h01, 1'b0},
		'{1'b1, 6'h3f, 8'h5a, 8'h00, 1'b1},
		'{1'b0, 6'h3f, 8'h00, 8'h00, 1'b1}
	};

	// ----------------------------------------
	// Clock and design
	// ----------------------------------------
	always #50 pclk = ~pclk;

	split_timer_cmd_irq_ctrl #(.ADDR_WIDTH(8)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .pslverr(pslverr), .prdata(prdata),
		.debug_halt(debug_halt), .irq(irq));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	// One bus transfer, held until pready
	task automatic apb(input logic w, input logic [5:0] idx,
		input logic [7:0] data);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h00_0000, data};
		@(posedge pclk);
		penable <= 1'b1;
		// Wait for the answer; only the watchdog ends a hang
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Read and compare one register
	task automatic expect_rd(input logic [5:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		check(rd, {24'h00_0000, exp});
	endtask

	// Settle, then look at the interrupt line
	task automatic expect_irq(input logic exp);
		@(negedge pclk);
		check(32'(irq), 32'(exp));
	endtask

	// Print counts and verdict, end the run
	task automatic give_verdict();
		$display("counts: %0d compared, %0d mismatched",
			samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	initial
	begin
		repeat (20000) @(posedge pclk);
		failures++;
		$display("watchdog expired");
		give_verdict();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		// Split map hidden until enabled
		apb(1'b0, split_timer_pkg::IDX_INT_ENABLE, 8'h00);
		check(32'(err), 32'h0000_0001);
		apb(1'b1, split_timer_pkg::IDX_DUAL_BYTE, 8'h01);
		expect_rd(split_timer_pkg::IDX_DUAL_BYTE, 8'h01);
		$display("test split map done");
		// Table of plain accesses
		foreach (rows[i])
		begin
			apb(rows[i].wr, rows[i].idx, rows[i].data);
			check(32'(err), 32'(rows[i].err_exp));
			if (rows[i].wr === 1'b0)
				check(rd, {24'h00_0000, rows[i].rd_exp});
		end
		apb(1'b1, split_timer_pkg::IDX_DEBUG_RUN, 8'h00);
		$display("test register table done");
		// Counting raises flags, which stick
		apb(1'b1, split_timer_pkg::IDX_LOW_PERIOD, 8'h05);
		apb(1'b1, split_timer_pkg::IDX_LOW_COUNTER, 8'h03);
		apb(1'b1, 6'(split_timer_pkg::IDX_LOW_COMPARE0
			+ split_timer_pkg::IDX_COMPARE_STEP), 8'h02);
		apb(1'b1, 6'(split_timer_pkg::IDX_LOW_COMPARE0
			+ 2 * split_timer_pkg::IDX_COMPARE_STEP), 8'h40);
		apb(1'b1, split_timer_pkg::IDX_CTRL_ENABLE, 8'h01);
		repeat (30) @(posedge pclk);
		apb(1'b1, split_timer_pkg::IDX_CTRL_ENABLE, 8'h00);
		expect_rd(split_timer_pkg::IDX_INT_FLAG, 8'h33);
		repeat (20) @(posedge pclk);
		expect_rd(split_timer_pkg::IDX_INT_FLAG, 8'h33);
		apb(1'b1, split_timer_pkg::IDX_INT_ENABLE, 8'h02);
		expect_irq(1'b1);
		apb(1'b1, split_timer_pkg::IDX_INT_FLAG, 8'h01);
		expect_rd(split_timer_pkg::IDX_INT_FLAG, 8'h32);
		apb(1'b1, split_timer_pkg::IDX_INT_ENABLE, 8'h01);
		expect_irq(1'b0);
		apb(1'b1, split_timer_pkg::IDX_INT_ENABLE, 8'h20);
		expect_irq(1'b1);
		apb(1'b1, split_timer_pkg::IDX_INT_FLAG, 8'h20);
		expect_irq(1'b0);
		$display("test flags and interrupt done");
		// Reserved codes and targets do nothing
		apb(1'b1, split_timer_pkg::IDX_CMD_CLEAR, 8'h03);
		apb(1'b1, split_timer_pkg::IDX_LOW_COUNTER, 8'h01);
		apb(1'b1, split_timer_pkg::IDX_CMD_SET, 8'h07);
		expect_rd(split_timer_pkg::IDX_LOW_COUNTER, 8'h01);
		apb(1'b1, split_timer_pkg::IDX_CMD_CLEAR, 8'h03);
		apb(1'b1, split_timer_pkg::IDX_CMD_SET, 8'h09);
		expect_rd(split_timer_pkg::IDX_LOW_COUNTER, 8'h01);
		apb(1'b1, split_timer_pkg::IDX_CMD_CLEAR, 8'h03);
		apb(1'b1, split_timer_pkg::IDX_CMD_SET, 8'h08);
		expect_rd(split_timer_pkg::IDX_LOW_COUNTER, 8'h01);
		// Restart loads both periods
		apb(1'b1, split_timer_pkg::IDX_CMD_SET, 8'h0b);
		expect_rd(split_timer_pkg::IDX_LOW_COUNTER, 8'h05);
		expect_rd(split_timer_pkg::IDX_HIGH_COUNTER, 8'hff);
		// Hard reset refused while enabled, then taken
		apb(1'b1, split_timer_pkg::IDX_CTRL_ENABLE, 8'h01);
		apb(1'b1, split_timer_pkg::IDX_CMD_SET, 8'h0f);
		expect_rd(split_timer_pkg::IDX_LOW_PERIOD, 8'h05);
		apb(1'b1, split_timer_pkg::IDX_CTRL_ENABLE, 8'h00);
		apb(1'b1, split_timer_pkg::IDX_CMD_SET, 8'h0f);
		expect_rd(split_timer_pkg::IDX_LOW_PERIOD, 8'hff);
		expect_rd(split_timer_pkg::IDX_LOW_COUNTER, 8'h00);
		$display("test commands done");
		// Debug halt freezes unless run bit set
		debug_halt <= 1'b1;
		apb(1'b1, split_timer_pkg::IDX_CTRL_ENABLE, 8'h01);
		apb(1'b0, split_timer_pkg::IDX_LOW_COUNTER, 8'h00);
		keep = rd;
		repeat (10) @(posedge pclk);
		expect_rd(split_timer_pkg::IDX_LOW_COUNTER, keep[7:0]);
		apb(1'b1, split_timer_pkg::IDX_DEBUG_RUN, 8'h01);
		apb(1'b0, split_timer_pkg::IDX_LOW_COUNTER, 8'h00);
		keep = rd;
		repeat (10) @(posedge pclk);
		apb(1'b0, split_timer_pkg::IDX_LOW_COUNTER, 8'h00);
		check(32'(rd !== keep), 32'h0000_0001);
		debug_halt <= 1'b0;
		// Counter write beats counting
		apb(1'b1, split_timer_pkg::IDX_LOW_COUNTER, 8'h80);
		apb(1'b0, split_timer_pkg::IDX_LOW_COUNTER, 8'h00);
		// Written value, stepped once before the read's setup edge
		check(rd, 32'h0000_007f);
		apb(1'b1, split_timer_pkg::IDX_CTRL_ENABLE, 8'h00);
		$display("test debug and priority done");
		// Second reset in mid-run
		apb(1'b1, split_timer_pkg::IDX_INT_ENABLE, 8'h73);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		expect_irq(1'b0);
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, split_timer_pkg::IDX_INT_FLAG, 8'h00);
		check(32'(err), 32'h0000_0001);
		apb(1'b1, split_timer_pkg::IDX_DUAL_BYTE, 8'h01);
		expect_rd(split_timer_pkg::IDX_INT_ENABLE, 8'h00);
		expect_rd(split_timer_pkg::IDX_INT_FLAG, 8'h00);
		expect_rd(split_timer_pkg::IDX_HIGH_PERIOD, 8'hff);
		$display("test second reset done");
		give_verdict();
	end
endmodule
